/* rtl/tx_align_pkg.sv */
// shared constants, types and encodings for the transmit input clocking block
package tx_align_pkg;

    // three-level static selects, Gray-ordered low, mid, high
    typedef enum logic [1:0] {
        LVL_LOW  = 2'h0,
        LVL_MID  = 2'h1,
        LVL_HIGH = 2'h3
    } level3_e;

    // phase-align buffer alignment states
    typedef enum logic [1:0] {
        ALN_HOLD = 2'h0,
        ALN_FILL = 2'h1,
        ALN_RUN  = 2'h3
    } align_state_e;

    // one captured character with its side information
    typedef struct packed {
        logic [7:0] data;
        logic [1:0] ctl;
        logic sc;
        logic par_err;
    } char_s;

    localparam int CHAN_NUM = 2;
    localparam int CHAN_A = 0;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_STAGES = 2;
    localparam int RST_LOW_EDGES = 2;

    localparam logic [4:0] PLL_MULT_FULL = 5'hA;
    localparam logic [4:0] PLL_MULT_HALF = 5'h14;

    // control code that, with special select high, starts a word sync
    localparam logic [1:0] WORD_SYNC_CTL = 2'h3;

    localparam logic [1:0] LVL_RESET = 2'h0;
    localparam logic [1:0] RST_CNT_RESET = 2'h0;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic [2:0] SYNC_RESET_HI = 3'h7;
    localparam logic [11:0] CHAR_RESET = 12'h000;

endpackage

/* rtl/phase_align_fifo.sv */
// small synchronous fifo used as a per-channel phase-align buffer
`timescale 1ns/1ps
module phase_align_fifo
    import tx_align_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4,
    parameter int AW = $clog2(DEPTH)
)
(
    input wire logic clk_i,                 // system clock
    input wire logic arst_n_i,              // async reset, active low
    input wire logic flush_i,               // empty the buffer
    input wire logic in_valid_i,            // write request
    output logic in_ready_o,                // room for a word
    input wire logic [WIDTH-1:0] in_data_i, // write data
    output logic out_valid_o,               // word available
    input wire logic out_ready_i,           // read request
    output logic [WIDTH-1:0] out_data_o,    // read data
    output logic [AW:0] level_o             // words held
);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] cnt_ff;
    logic [WIDTH-1:0] rdata_ff;
    wire do_wr;
    wire do_rd;
    wire [AW-1:0] rd_next;

    // count is one bit wider than the pointers so that a full buffer is seen
    assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH)) || out_ready_i;
    assign out_valid_o = (cnt_ff != '0);
    assign do_wr = in_valid_i && in_ready_o && !flush_i;
    assign do_rd = out_valid_o && out_ready_i && !flush_i;
    assign rd_next = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
    assign level_o = cnt_ff;
    assign out_data_o = rdata_ff;

    always_ff @(posedge clk_i)
    begin
        if (do_wr)
        begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end
        else if (flush_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr_ff <= rd_next;
            end
            cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // registered head word; a lone write into an empty buffer goes straight in
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_ff <= '0;
        end
        else if (do_rd && (cnt_ff > (AW+1)'(1)))
        begin
            rdata_ff <= mem_ff[rd_next];
        end
        else if (do_wr && ((cnt_ff == '0) || (do_rd && (cnt_ff == (AW+1)'(1)))))
        begin
            rdata_ff <= in_data_i;
        end
    end

endmodule

/* rtl/tx_input_clocking_phase_align.sv */
// transmit input register clocking, phase-align buffers and parity check
`timescale 1ns/1ps
module tx_input_clocking_phase_align
    import tx_align_pkg::*;
#(
    parameter int NCH = CHAN_NUM,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_i,                              // 25 MHz system clock
    input wire logic arst_n_i,                           // async reset, active low
    input wire logic reference_clock_i,                  // reference clock pin
    input wire logic [NCH-1:0] tx_channel_input_clock_i, // per-channel input clocks
    input wire logic tx_phase_reset_n_i,                 // phase reset, active low
    input wire logic [1:0] tx_input_clock_source_sel_i,  // three-level clock select
    input wire logic ref_clock_rate_sel_i,               // high: half-rate reference
    input wire logic [1:0] parity_check_control_i,       // three-level parity control
    input wire logic special_char_sel_i,                 // special character select
    input wire logic [NCH-1:0][7:0] tx_data_in_i,        // parallel characters
    input wire logic [NCH-1:0][1:0] tx_control_code_i,   // per-channel control codes
    input wire logic [NCH-1:0] tx_parity_i,              // odd parity inputs
    output char_s [NCH-1:0] enc_char_o,                  // characters to encoder
    output logic [NCH-1:0] enc_valid_o,                  // one-cycle character strobe
    output logic [NCH-1:0] enc_word_sync_o,              // character starts word sync
    output logic [NCH-1:0] tx_channel_error_flag_o,      // sticky buffer overflow/underflow error
    output logic [4:0] transmit_pll_mult_o,              // pll multiplier
    output logic buffer_bypassed_o                       // phase-align buffer bypassed
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $bits(char_s);
    localparam logic [AW:0] HALF_LVL = (AW+1)'(DEPTH / 2);

    function automatic logic is_word_sync(input char_s c);
        is_word_sync = c.sc && (c.ctl == WORD_SYNC_CTL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [2:0] ref_sync_ff;
    logic [NCH-1:0][2:0] chclk_sync_ff;
    logic [SYNC_STAGES-1:0] prst_sync_ff;
    logic [NCH-1:0][SYNC_STAGES-1:0][11:0] din_sync_ff;
    logic [SYNC_STAGES-1:0] sc_sync_ff;
    logic [SYNC_STAGES-1:0][5:0] cfg_sync_ff;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ref_sync_ff <= SYNC_RESET;
            prst_sync_ff <= '1;
            sc_sync_ff <= '0;
            cfg_sync_ff <= '0;
        end
        else
        begin
            ref_sync_ff <= {ref_sync_ff[1:0], reference_clock_i};
            prst_sync_ff <= {prst_sync_ff[0], tx_phase_reset_n_i};
            sc_sync_ff <= {sc_sync_ff[0], special_char_sel_i};
            cfg_sync_ff <= {cfg_sync_ff[0], {tx_input_clock_source_sel_i,
                ref_clock_rate_sel_i, parity_check_control_i, 1'b0}};
        end
    end

    genvar s;
    generate
        for (s = 0; s < NCH; s++)
        begin : g_sync
            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    chclk_sync_ff[s] <= SYNC_RESET;
                    din_sync_ff[s] <= '0;
                end
                else
                begin
                    chclk_sync_ff[s] <= {chclk_sync_ff[s][1:0], tx_channel_input_clock_i[s]};
                    din_sync_ff[s] <= {din_sync_ff[s][0],
                        {tx_data_in_i[s], tx_control_code_i[s], tx_parity_i[s], 1'b0}};
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode and edge strobes

    wire [5:0] cfg_w = cfg_sync_ff[SYNC_STAGES-1];
    wire [1:0] src_sel_w = cfg_w[5:4];
    wire half_rate_w = cfg_w[3];
    wire par_en_w = (cfg_w[2:1] != LVL_LOW);
    wire ref_rise_w = ref_sync_ff[1] && !ref_sync_ff[2];
    wire ref_fall_w = !ref_sync_ff[1] && ref_sync_ff[2];
    wire prst_n_w = prst_sync_ff[SYNC_STAGES-1];
    wire sc_w = sc_sync_ff[SYNC_STAGES-1];
    wire [NCH-1:0] ch_rise_w;
    wire [NCH-1:0] cap_stb_w;

    // both reference edges at half rate
    wire ref_stb_w = ref_rise_w || (half_rate_w && ref_fall_w);
    // bypass when select and rate are low
    wire bypass_w = (src_sel_w == LVL_LOW) && !half_rate_w;
    assign transmit_pll_mult_o = half_rate_w ? PLL_MULT_HALF : PLL_MULT_FULL;
    assign buffer_bypassed_o = bypass_w;

    // reference-edge count of phase reset sampled low
    logic [1:0] rst_low_cnt_ff;
    logic align_req_ff;
    wire rst_taken_w = (rst_low_cnt_ff == 2'(RST_LOW_EDGES - 1)) && !prst_n_w && ref_rise_w;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_low_cnt_ff <= RST_CNT_RESET;
            align_req_ff <= 1'b0;
        end
        else if (ref_rise_w)
        begin
            // reset counted over consecutive reference edges
            if (prst_n_w || bypass_w)
            begin
                rst_low_cnt_ff <= RST_CNT_RESET;
            end
            else if (rst_low_cnt_ff != 2'(RST_LOW_EDGES - 1))
            begin
                rst_low_cnt_ff <= rst_low_cnt_ff + 2'h1;
            end
            // align while low, freeze when high
            align_req_ff <= !prst_n_w && !bypass_w &&
                (rst_taken_w || align_req_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel capture, phase-align buffer and error flag

    align_state_e [NCH-1:0] aln_ff;
    char_s [NCH-1:0] cap_ff;
    logic [NCH-1:0] cap_vld_ff;
    char_s [NCH-1:0] out_ff;
    logic [NCH-1:0] out_vld_ff;
    logic [NCH-1:0] err_ff;
    logic sc_a_ff;

    // special select follows channel A's strobe
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sc_a_ff <= 1'b0;
        end
        else
        begin
            sc_a_ff <= cap_stb_w[CHAN_A] ? sc_w : sc_a_ff;
        end
    end

    genvar c;
    generate
        for (c = 0; c < NCH; c++)
        begin : g_chan
            wire [11:0] din_w = din_sync_ff[c][SYNC_STAGES-1];
            wire fifo_in_rdy;
            wire fifo_out_vld;
            wire [CW-1:0] fifo_out_data;
            wire [AW:0] fifo_lvl;
            char_s nxt_cap;
            assign ch_rise_w[c] = chclk_sync_ff[c][1] && !chclk_sync_ff[c][2];
            assign cap_stb_w[c] = (src_sel_w == LVL_LOW) ? ref_stb_w :
                                  (src_sel_w == LVL_MID) ? ch_rise_w[c] : ch_rise_w[CHAN_A];
            assign nxt_cap.data = din_w[11:4];
            assign nxt_cap.ctl = din_w[3:2];
            // special select carried with control code
            assign nxt_cap.sc = cap_stb_w[CHAN_A] ? sc_w : sc_a_ff;
            assign nxt_cap.par_err = par_en_w && !(^{din_w[11:4], din_w[1]});

            // flush while aligning, then refill to half
            wire flush_w = bypass_w || (aln_ff[c] == ALN_HOLD);
            wire rd_en_w = (aln_ff[c] == ALN_RUN) && ref_stb_w;
            // a full buffer drops the character
            wire ovf_w = cap_vld_ff[c] && !fifo_in_rdy && !flush_w;
            wire unf_w = rd_en_w && !fifo_out_vld;
            wire sync_sent_w = out_vld_ff[c] && is_word_sync(out_ff[c]);

            phase_align_fifo #(
                .WIDTH(CW),
                .DEPTH(DEPTH)
            ) u_fifo (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .flush_i(flush_w),
                .in_valid_i(cap_vld_ff[c]),
                .in_ready_o(fifo_in_rdy),
                .in_data_i(cap_ff[c]),
                .out_valid_o(fifo_out_vld),
                .out_ready_i(rd_en_w),
                .out_data_o(fifo_out_data),
                .level_o(fifo_lvl)
            );

            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    cap_ff[c] <= CHAR_RESET;
                    cap_vld_ff[c] <= 1'b0;
                end
                else
                begin
                    cap_vld_ff[c] <= cap_stb_w[c];
                    cap_ff[c] <= cap_stb_w[c] ? nxt_cap : cap_ff[c];
                end
            end

            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    aln_ff[c] <= ALN_HOLD;
                end
                else if (align_req_ff || bypass_w)
                begin
                    aln_ff[c] <= ALN_HOLD;
                end
                else
                begin
                    unique case (aln_ff[c])
                        ALN_HOLD: aln_ff[c] <= ALN_FILL;
                        ALN_FILL: aln_ff[c] <= (fifo_lvl >= HALF_LVL) ? ALN_RUN : ALN_FILL;
                        ALN_RUN: aln_ff[c] <= ALN_RUN;
                        default: aln_ff[c] <= ALN_HOLD;
                    endcase
                end
            end

            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    out_ff[c] <= CHAR_RESET;
                    out_vld_ff[c] <= 1'b0;
                end
                else if (bypass_w)
                begin
                    out_vld_ff[c] <= cap_vld_ff[c];
                    out_ff[c] <= cap_vld_ff[c] ? cap_ff[c] : out_ff[c];
                end
                else
                begin
                    out_vld_ff[c] <= rd_en_w && fifo_out_vld;
                    out_ff[c] <= (rd_en_w && fifo_out_vld) ? char_s'(fifo_out_data) : out_ff[c];
                end
            end

            // sticky fault, set wins over clear
            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    err_ff[c] <= 1'b0;
                end
                else if (!bypass_w && (ovf_w || unf_w))
                begin
                    err_ff[c] <= 1'b1;
                end
                else if (sync_sent_w || align_req_ff || bypass_w)
                begin
                    err_ff[c] <= 1'b0;
                end
            end

            assign enc_char_o[c] = out_ff[c];
            assign enc_valid_o[c] = out_vld_ff[c];
            assign enc_word_sync_o[c] = out_vld_ff[c] && is_word_sync(out_ff[c]);
            assign tx_channel_error_flag_o[c] = err_ff[c];
        end
    endgenerate

endmodule

/* testbench/tx_align_asserts.sv */
// port-level assertions for the transmit input clocking block
`timescale 1ns/1ps
module tx_align_asserts
    import tx_align_pkg::*;
#(
    parameter int NCH = CHAN_NUM
)
(
    input wire logic clk_i, // clock
    input wire logic arst_n_i, // reset
    input wire logic reference_clock_i, // ref pin
    input wire logic ref_clock_rate_sel_i, // rate
    input wire logic [1:0] tx_input_clock_source_sel_i, // select
    input wire logic [1:0] parity_check_control_i, // parity ctl
    input wire char_s [NCH-1:0] enc_char_o, // chars
    input wire logic [NCH-1:0] enc_valid_o, // strobes
    input wire logic [NCH-1:0] enc_word_sync_o, // word sync
    input wire logic [NCH-1:0] tx_channel_error_flag_o, // errors
    input wire logic [4:0] transmit_pll_mult_o, // multiplier
    input wire logic buffer_bypassed_o // bypass
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    mult_half_a:
    assert property (ref_clock_rate_sel_i [*4] |-> transmit_pll_mult_o == 5'h14)
        else $error("multiplier not twenty");
    mult_full_a:
    assert property (!ref_clock_rate_sel_i [*4] |-> transmit_pll_mult_o == 5'h0A)
        else $error("multiplier not ten");
    bypass_on_a:
    assert property ((tx_input_clock_source_sel_i == 2'h0 && !ref_clock_rate_sel_i) [*4]
        |-> buffer_bypassed_o) else $error("bypass missing");
    bypass_off_a:
    assert property ((tx_input_clock_source_sel_i != 2'h0 || ref_clock_rate_sel_i) [*4]
        |-> !buffer_bypassed_o) else $error("bypass wrongly set");
    bypass_lat_a:
    assert property (buffer_bypassed_o && $rose(reference_clock_i) |-> ##[4:6] enc_valid_o[0])
        else $error("bypass character missing");
    word_sync_a:
    assert property (enc_word_sync_o[0] == (enc_valid_o[0] && enc_char_o[0].sc
        && enc_char_o[0].ctl == WORD_SYNC_CTL)) else $error("word sync mismatch");
    char_hold_a:
    assert property (!enc_valid_o[1] |-> $stable(enc_char_o[1]))
        else $error("character changed without strobe");
    par_off_a:
    assert property ((parity_check_control_i == 2'h0) [*8] ##0 enc_valid_o[0]
        |-> !enc_char_o[0].par_err) else $error("parity error while off");
    err_bypass_a:
    assert property (buffer_bypassed_o [*3] |-> !tx_channel_error_flag_o[0])
        else $error("error flag in bypass");
    sync_clear_a:
    assert property (enc_word_sync_o[0] |=> !tx_channel_error_flag_o[0])
        else $error("flag kept after word sync");
endmodule
bind tx_input_clocking_phase_align tx_align_asserts #(.NCH(NCH)) chk (.clk_i, .arst_n_i,
    .reference_clock_i, .ref_clock_rate_sel_i, .tx_input_clock_source_sel_i,
    .parity_check_control_i, .enc_char_o, .enc_valid_o, .enc_word_sync_o,
    .tx_channel_error_flag_o, .transmit_pll_mult_o, .buffer_bypassed_o);

/* testbench/host_char_source.sv */
// host model: reference clock, channel clocks and characters
`timescale 1ns/1ps
module host_char_source
    import tx_align_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic ref_run_i, // reference runs
    input wire logic chb_run_i, // channel b clock runs
    input wire logic half_i, // new char each half period
    input wire logic bad_par_i, // wrong parity
    input wire logic sc_i, // special select
    input wire logic [1:0] ctl_i, // control code
    output logic ref_clk_o, // reference clock
    output logic [CHAN_NUM-1:0] ch_clk_o, // channel clocks
    output logic [CHAN_NUM-1:0][7:0] data_o, // characters
    output logic [CHAN_NUM-1:0][1:0] ctl_o, // control codes
    output logic [CHAN_NUM-1:0] par_o, // odd parity
    output logic sc_o // special select
);
    logic [2:0] ph_ff = 3'h0;
    logic [7:0] cnt_ff = 8'h00;
    logic sc_ff = 1'b0;
    logic bad_ff = 1'b0;
    logic [1:0] ctl_ff = 2'h0;
    // data moves midway between the edges that sample it
    wire step = half_i ? (ph_ff[1:0] == 2'h1) : (ph_ff == 3'h7);
    assign ref_clk_o = ref_run_i & ph_ff[2];
    assign ch_clk_o = {chb_run_i & ph_ff[2], ph_ff[2]};
    assign data_o = {~cnt_ff, cnt_ff};
    assign ctl_o = {ctl_ff, ctl_ff};
    assign sc_o = sc_ff;
    assign par_o = {2{~^cnt_ff ^ bad_ff}};
    always_ff @(posedge clk_i)
    begin
        ph_ff <= ph_ff + 3'h1;
        if (step)
        begin
            cnt_ff <= cnt_ff + 8'h01;
            sc_ff <= sc_i;
            ctl_ff <= ctl_i;
            bad_ff <= bad_par_i;
        end
    end
endmodule

/* testbench/tx_input_clocking_phase_align_tb.sv */
// self-checking bench for the transmit input clocking block
`timescale 1ns/1ps
module tx_input_clocking_phase_align_tb;
    import tx_align_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic prst_n = 1'b1;
    logic [1:0] sel = 2'h0;
    logic rate = 1'b0;
    logic [1:0] par_ctl = 2'h1;
    logic ref_run = 1'b1;
    logic chb_run = 1'b1;
    logic bad_par = 1'b0;
    logic sc = 1'b0;
    logic [1:0] ctl = 2'h0;
    logic chk_on = 1'b0;
    logic ref_clk, sc_w, byp;
    logic [1:0] ch_clk, par_w, valid, ws, err;
    logic [1:0][7:0] data_w;
    logic [1:0][1:0] ctl_w;
    char_s [1:0] chr;
    logic [4:0] mult;
    logic [7:0] last [2];
    int vcnt [2] = '{0, 0};
    int wcnt [2] = '{0, 0};
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int v0;
    int v1;
    host_char_source host (.clk_i, .ref_run_i(ref_run), .chb_run_i(chb_run), .half_i(rate),
        .bad_par_i(bad_par), .sc_i(sc), .ctl_i(ctl), .ref_clk_o(ref_clk), .ch_clk_o(ch_clk),
        .data_o(data_w), .ctl_o(ctl_w), .par_o(par_w), .sc_o(sc_w));
    tx_input_clocking_phase_align uut (.clk_i, .arst_n_i, .reference_clock_i(ref_clk),
        .tx_channel_input_clock_i(ch_clk), .tx_phase_reset_n_i(prst_n),
        .tx_input_clock_source_sel_i(sel), .ref_clock_rate_sel_i(rate),
        .parity_check_control_i(par_ctl), .special_char_sel_i(sc_w), .tx_data_in_i(data_w),
        .tx_control_code_i(ctl_w), .tx_parity_i(par_w), .enc_char_o(chr), .enc_valid_o(valid),
        .enc_word_sync_o(ws), .tx_channel_error_flag_o(err), .transmit_pll_mult_o(mult),
        .buffer_bypassed_o(byp));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // wait whole reference periods
    task automatic per(input int n);
        repeat (8 * n) @(posedge clk_i);
    endtask
    // phase reset over three reference rises, then settle
    task automatic prst();
        @(posedge clk_i);
        prst_n <= 1'b0;
        per(3);
        prst_n <= 1'b1;
        per(6);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            close_out();
        end
        for (int c = 0; c < 2; c++)
        begin
            if (valid[c] === 1'b1)
            begin
                vcnt[c]++;
                if (ws[c] === 1'b1)
                    wcnt[c]++;
                if (chk_on)
                begin
                    chk("data", c ? last[c] - 8'h01 : last[c] + 8'h01, chr[c].data);
                    chk("par_err", {7'h00, bad_par}, {7'h00, chr[c].par_err});
                end
                last[c] = chr[c].data;
            end
        end
    end
    task automatic t_bypass();
        per(3);
        chk_on = 1'b1;
        per(4);
        chk_on = 1'b0;
        bad_par <= 1'b1;
        per(2);
        chk_on = 1'b1;
        per(3);
        v0 = vcnt[0];
        prst_n <= 1'b0;
        per(4);
        chk("ignored reset", 8'h04, 8'(vcnt[0] - v0));
        prst_n <= 1'b1;
        chk_on = 1'b0;
        par_ctl <= 2'h0;
        bad_par <= 1'b0;
        per(4);
        par_ctl <= 2'h1;
    endtask
    task automatic t_half();
        @(negedge ref_clk);
        @(posedge clk_i);
        rate <= 1'b1;
        per(2);
        chk("mult", 8'h14, {3'h0, mult});
        chk("bypass", 8'h00, {7'h00, byp});
        prst();
        chk_on = 1'b1;
        v0 = vcnt[0];
        per(8);
        chk("both edges", 8'h10, 8'(vcnt[0] - v0));
        chk("no fault", 8'h00, {6'h00, err});
        chk_on = 1'b0;
    endtask
    task automatic t_fault();
        rate <= 1'b0;
        per(1);
        sel <= 2'h1;
        per(2);
        prst();
        chk("aligned", 8'h00, {6'h00, err});
        ref_run <= 1'b0;
        per(6);
        chk("overflow", 8'h03, {6'h00, err});
        ref_run <= 1'b1;
        prst();
        chk("cleared", 8'h00, {6'h00, err});
        v0 = wcnt[1];
        v1 = wcnt[0];
        sc <= 1'b1;
        ctl <= 2'h3;
        per(2);
        sc <= 1'b0;
        ctl <= 2'h0;
        per(4);
        chk("sync on b", 8'h02, 8'(wcnt[1] - v0));
        chk("sync on a", 8'h02, 8'(wcnt[0] - v1));
    endtask
    task automatic t_high();
        sel <= 2'h3;
        chb_run <= 1'b0;
        per(2);
        prst();
        v0 = vcnt[1];
        per(8);
        chk("channel a clock", 8'h08, 8'(vcnt[1] - v0));
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    initial
    begin
        @(posedge clk_i);
        chk("reset mult", 8'h0A, {3'h0, mult});
        chk("reset bypass", 8'h01, {7'h00, byp});
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_bypass();
        t_half();
        t_fault();
        t_high();
        close_out();
    end
endmodule
